// File: pkg/drs_consts.svh
// constants for the dual rail enable sequencer: offsets, fields, resets, times
// assumes one 100 MHz reference clock; included by package and modules alike
`ifndef DRS_CONSTS_SVH
`define DRS_CONSTS_SVH

`define DRS_CLK_MHZ        100
`define DRS_CNT_W          18

// register offsets
`define DRS_OFS_STATUS     8'h04
`define DRS_OFS_ENABLE     8'h05

// status register fields
`define DRS_ST_REBOOT      7
`define DRS_ST_TOGETHER    4
`define DRS_STATUS_RST     8'h00
`define DRS_STATUS_WMASK   8'h90

// enable register fields
`define DRS_EN_SS_FAST     7
`define DRS_EN_HIZ         6
`define DRS_EN_UVP_SD      5
`define DRS_EN_OFF_IMM     4
`define DRS_EN_POS         2
`define DRS_EN_NEG         1
`define DRS_EN_BOOST       0
`define DRS_ENABLE_RST     8'h27
`define DRS_ENABLE_WMASK   8'hF7

// times in microseconds at default output voltages
`define DRS_SEQ_DLY_US     2000
`define DRS_POS_SS_US      1200
`define DRS_NEG_SS_US      1800
`define DRS_FAST_SS_US     700
`define DRS_BOOST_SS_US    470

// interval timer slots
`define DRS_TMR_SEQ        0
`define DRS_TMR_POSOFF     1
`define DRS_TMR_DIS        2
`define DRS_TMR_N          3

`endif

// File: pkg/drs_pkg.sv
// types shared by the sequencer top and its interval timer
// assumes drs_consts.svh on the include path
`include "drs_consts.svh"

package drs_pkg;

    typedef logic [`DRS_CNT_W-1:0] drs_count_t;

    // rail controls handed to the analog regulators
    typedef struct packed {
        logic boost_rail_en;
        logic positive_rail_en;
        logic negative_rail_en;
        logic pos_discharge_en;
        logic neg_discharge_en;
        logic boost_pfm_allow;
        logic pump_pfm_allow;
    } drs_rails_s;

    // nominal soft-start durations in reference cycles
    typedef struct packed {
        drs_count_t boost_ss;
        drs_count_t pos_ss;
        drs_count_t neg_ss;
    } drs_ss_s;

    typedef struct packed {
        drs_count_t count;
        logic       active;
        logic       done;
    } drs_tmr_s;

    typedef struct packed {
        logic       pos_s1;
        logic       pos_s2;
        logic       neg_s1;
        logic       neg_s2;
        logic       uv_s1;
        logic       uv_s2;
        logic       bss_s1;
        logic       bss_s2;
        logic       pos_d;
        logic       neg_d;
        logic       boost_done_d;
        logic [7:0] stage_status;
        logic [7:0] stage_enable;
        logic [7:0] status;
        logic [7:0] enable;
        logic [7:0] rdata;
        drs_rails_s rails;
        drs_ss_s    ss;
    } drs_state_s;

endpackage

// File: core/drs_interval_timer.sv
// one restartable interval counter on the reference clock
// assumes restart and clear come from logic on the same clock
`timescale 1ns/100ps
`include "drs_consts.svh"

module drs_interval_timer
    import drs_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_restart,
    input  wire logic              i_clear,
    input  wire drs_pkg::drs_count_t i_limit,
    output logic                   o_running,
    output logic                   o_expired
);

    drs_tmr_s q;
    drs_tmr_s next_q;

    ////////////////////////////////////////////////////////////////////////////
    // clear wins over restart so a dropped condition never leaves a stale interval
    always_comb
    begin
        next_q = q;
        if (i_clear)
        begin
            next_q = '0;
        end
        else if (i_restart)
        begin
            next_q.count  = '0;
            next_q.active = 1'b1;
            next_q.done   = 1'b0;
        end
        else if (q.active)
        begin
            if (q.count + drs_count_t'(1) >= i_limit)
            begin
                next_q.active = 1'b0;
                next_q.done   = 1'b1;
            end
            else
            begin
                next_q.count = q.count + drs_count_t'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign o_running = q.active;
    assign o_expired = q.done;

endmodule

// File: core/drs_sequencer.sv
// dual rail enable sequencer: pins plus register bits to boost/positive/negative
// assumes pins, undervoltage and boost ramp-done arrive asynchronously;
// register port is driven by the serial slave on this clock, one byte per write
// Behaviour
// - boost on only with a pin high or the positive off delay running, and boost bit set, else everything off
// - negative rail needs its pin high and its enable bit set
// - positive rail needs its pin high or its off delay running, and its enable bit set
// - all three rail enable bits reset to one, pins alone suffice
// - undriven pins read low through a pull-down outside; the synchroniser resets low
// - positive ramp starts on pin, bit and boost ramp finished
// - sequenced negative start is later of 2ms after boost or pin high
// - status bit 4 picks sequenced start or both rails together
// - enable bit 7 picks 1.2/1.8ms or 0.7ms rail ramps
// - ramps have fixed slope; durations hold only at default voltages
// - each pin low drops its rail; both low also drops boost
// - enable bit 4 clear holds positive and boost 2ms after pin falls
// - input undervoltage drops every active regulator at once
// - positive discharge on 2ms after negative pin falls, again on its fall
// - enable bit 6 removes both output pull-downs, outputs float
// - light-load pulse mode only when its per-regulator bit allows
// - enable bits written in one transaction apply at its stop
`timescale 1ns/100ps
`include "drs_consts.svh"

module drs_sequencer
    import drs_pkg::*;
#(
    parameter int P_SEQ_DLY_CYC   = `DRS_SEQ_DLY_US * `DRS_CLK_MHZ,
    parameter int P_POS_SS_CYC    = `DRS_POS_SS_US * `DRS_CLK_MHZ,
    parameter int P_NEG_SS_CYC    = `DRS_NEG_SS_US * `DRS_CLK_MHZ,
    parameter int P_FAST_SS_CYC   = `DRS_FAST_SS_US * `DRS_CLK_MHZ,
    parameter int P_BOOST_SS_CYC  = `DRS_BOOST_SS_US * `DRS_CLK_MHZ
)
(
    input  wire logic          i_ref_clk,
    input  wire logic          i_resetn,
    input  wire logic          i_pos_rail_enable_pin,
    input  wire logic          i_neg_rail_enable_pin,
    input  wire logic          i_input_uvlo,
    input  wire logic          i_boost_ss_done,
    input  wire logic          i_boost_pfm_en,
    input  wire logic          i_pump_pfm_en,
    input  wire logic          i_reg_wr,
    input  wire logic [7:0]    i_reg_addr,
    input  wire logic [7:0]    i_reg_wdata,
    input  wire logic          i_xfer_stop,
    output logic [7:0]         o_reg_rdata,
    output drs_pkg::drs_rails_s o_rails,
    output drs_pkg::drs_ss_s   o_ss_cycles
);

    drs_state_s q;
    drs_state_s next_q;

    logic       tmr_restart [`DRS_TMR_N];
    logic       tmr_clear   [`DRS_TMR_N];
    drs_count_t tmr_limit   [`DRS_TMR_N];
    logic       tmr_running [`DRS_TMR_N];
    logic       tmr_expired [`DRS_TMR_N];

    // synchronised views
    logic pin_p;
    logic pin_n;
    logic uvlo;
    logic boost_done;
    logic pos_fall;
    logic neg_fall;
    logic boost_done_rise;
    logic pos_hold;
    logic boost_on;
    logic pos_on;
    logic neg_on;
    logic hiz;
    logic pos_dis;
    logic neg_dis;
    logic boost_pfm;
    logic pump_pfm;

    // a pin left floating is pulled low outside; reset value of the
    // synchroniser is also low so nothing starts before the pins settle
    assign pin_p      = q.pos_s2;
    assign pin_n      = q.neg_s2;
    assign uvlo       = q.uv_s2;
    assign boost_done = q.bss_s2 & q.rails.boost_rail_en;
    assign hiz        = q.enable[`DRS_EN_HIZ];

    assign pos_fall        = q.pos_d & ~pin_p;
    assign neg_fall        = q.neg_d & ~pin_n;
    assign boost_done_rise = boost_done & ~q.boost_done_d;

    ////////////////////////////////////////////////////////////////////////////
    // interval timers: sequencing delay, positive off delay, discharge window
    // one counter per interval rather than a shared timebase, so overlapping
    // windows never steal each other's count; costs three 18-bit counters

    assign tmr_restart[`DRS_TMR_SEQ]    = boost_done_rise;
    assign tmr_clear[`DRS_TMR_SEQ]      = ~boost_done;
    assign tmr_limit[`DRS_TMR_SEQ]      = drs_count_t'(P_SEQ_DLY_CYC);

    assign tmr_restart[`DRS_TMR_POSOFF] = pos_fall;
    assign tmr_clear[`DRS_TMR_POSOFF]   = pin_p | uvlo;
    assign tmr_limit[`DRS_TMR_POSOFF]   = drs_count_t'(P_SEQ_DLY_CYC);

    assign tmr_restart[`DRS_TMR_DIS]    = neg_fall;
    assign tmr_clear[`DRS_TMR_DIS]      = pin_n;
    assign tmr_limit[`DRS_TMR_DIS]      = drs_count_t'(P_SEQ_DLY_CYC);

    genvar gi;
    generate
        for (gi = 0; gi < `DRS_TMR_N; gi++)
        begin : g_tmr
            drs_interval_timer u_tmr
            (
                .i_ref_clk (i_ref_clk),
                .i_resetn  (i_resetn),
                .i_restart (tmr_restart[gi]),
                .i_clear   (tmr_clear[gi]),
                .i_limit   (tmr_limit[gi]),
                .o_running (tmr_running[gi]),
                .o_expired (tmr_expired[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // rail decisions

    always_comb
    begin
        // positive rail and boost linger after the pin falls unless immediate off;
        // the fall cycle itself counts, else the rail blinks off for one edge
        pos_hold = 1'b0;
        if (!q.enable[`DRS_EN_OFF_IMM])
        begin
            pos_hold = pos_fall | tmr_running[`DRS_TMR_POSOFF];
        end

        // undervoltage gates every term, no sequencing delay applies
        boost_on = 1'b0;
        if (!uvlo && q.enable[`DRS_EN_BOOST])
        begin
            boost_on = pin_p | pin_n | pos_hold;
        end

        pos_on = 1'b0;
        if (boost_on && boost_done && q.enable[`DRS_EN_POS])
        begin
            pos_on = pin_p | pos_hold;
        end

        // together mode skips the delay; otherwise wait for the 2ms mark
        neg_on = 1'b0;
        if (boost_on && boost_done && pin_n && q.enable[`DRS_EN_NEG])
        begin
            neg_on = q.status[`DRS_ST_TOGETHER]
                   | tmr_expired[`DRS_TMR_SEQ];
        end

        // discharge window opens on the negative pin fall itself and is held
        // again once the positive rail is off; hi-z mode removes both pull-downs
        pos_dis = 1'b0;
        neg_dis = 1'b0;
        if (!hiz)
        begin
            pos_dis = neg_fall | tmr_running[`DRS_TMR_DIS] | ~pos_on;
            neg_dis = ~neg_on;
        end

        // permit follows its rail; a rail that is off never changes mode
        boost_pfm = 1'b0;
        pump_pfm  = 1'b0;
        if (boost_on && i_boost_pfm_en)
        begin
            boost_pfm = 1'b1;
        end
        if (neg_on && i_pump_pfm_en)
        begin
            pump_pfm = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_q = q;

        // two-stage synchronisers for everything from outside the clock
        next_q.pos_s1 = i_pos_rail_enable_pin;
        next_q.pos_s2 = q.pos_s1;
        next_q.neg_s1 = i_neg_rail_enable_pin;
        next_q.neg_s2 = q.neg_s1;
        next_q.uv_s1  = i_input_uvlo;
        next_q.uv_s2  = q.uv_s1;
        next_q.bss_s1 = i_boost_ss_done;
        next_q.bss_s2 = q.bss_s1;

        next_q.pos_d        = pin_p;
        next_q.neg_d        = pin_n;
        next_q.boost_done_d = boost_done;

        // bytes land in staging; the live copy changes only at stop
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                `DRS_OFS_STATUS:
                begin
                    next_q.stage_status = i_reg_wdata & `DRS_STATUS_WMASK;
                end
                `DRS_OFS_ENABLE:
                begin
                    next_q.stage_enable = i_reg_wdata & `DRS_ENABLE_WMASK;
                end
                default:
                begin
                    // other addresses are not ours; the byte is dropped
                    next_q.stage_enable = q.stage_enable;
                end
            endcase
        end
        if (i_xfer_stop)
        begin
            if (q.stage_status[`DRS_ST_REBOOT])
            begin
                // reboot reverts all registers and then reads back as zero
                next_q.stage_status = `DRS_STATUS_RST;
                next_q.stage_enable = `DRS_ENABLE_RST;
                next_q.status       = `DRS_STATUS_RST;
                next_q.enable       = `DRS_ENABLE_RST;
            end
            else
            begin
                next_q.status = q.stage_status;
                next_q.enable = q.stage_enable;
            end
        end

        // read-back shows the live copy so software sees what is in force
        case (i_reg_addr)
            `DRS_OFS_STATUS: next_q.rdata = q.status;
            `DRS_OFS_ENABLE: next_q.rdata = q.enable;
            default:         next_q.rdata = 8'h00;
        endcase

        next_q.rails.boost_rail_en    = boost_on;
        next_q.rails.positive_rail_en = pos_on;
        next_q.rails.negative_rail_en = neg_on;

        next_q.rails.pos_discharge_en = pos_dis;
        next_q.rails.neg_discharge_en = neg_dis;
        next_q.rails.boost_pfm_allow  = boost_pfm;
        next_q.rails.pump_pfm_allow   = pump_pfm;

        // nominal ramp times only; the analog ramp is slope based and
        // stretches or shrinks with the programmed output voltage
        next_q.ss.boost_ss = drs_count_t'(P_BOOST_SS_CYC);
        if (q.enable[`DRS_EN_SS_FAST])
        begin
            next_q.ss.pos_ss = drs_count_t'(P_FAST_SS_CYC);
            next_q.ss.neg_ss = drs_count_t'(P_FAST_SS_CYC);
        end
        else
        begin
            next_q.ss.pos_ss = drs_count_t'(P_POS_SS_CYC);
            next_q.ss.neg_ss = drs_count_t'(P_NEG_SS_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            q              <= '0;
            q.stage_status <= `DRS_STATUS_RST;
            q.stage_enable <= `DRS_ENABLE_RST;
            q.status       <= `DRS_STATUS_RST;
            q.enable       <= `DRS_ENABLE_RST;
            q.rails        <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign o_reg_rdata = q.rdata;
    assign o_rails     = q.rails;
    assign o_ss_cycles = q.ss;

endmodule

// File: dv/drs_seq_props.sv
// port checker for the rail sequencer: gating, latency, pulse-mode permits
// assumes the 3-edge pin/undervoltage path and one reference clock
`timescale 1ns/100ps

module drs_seq_props
    import drs_pkg::*;
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_neg_rail_enable_pin,
    input  wire logic             i_input_uvlo,
    input  wire logic             i_boost_ss_done,
    input  wire logic             i_boost_pfm_en,
    input  wire logic             i_pump_pfm_en,
    input  wire drs_pkg::drs_rails_s o_rails
);
    import drs_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_uv_held;
        i_input_uvlo[*3];
    endsequence
    sequence s_all_off;
        !o_rails.boost_rail_en && !o_rails.positive_rail_en && !o_rails.negative_rail_en;
    endsequence

    a_uv_drops_all: assert property (s_uv_held |=> s_all_off)
        else $error("rails stay on under undervoltage");
    a_neg_pin_off: assert property ((!i_neg_rail_enable_pin)[*3] |=> !o_rails.negative_rail_en)
        else $error("negative rail on with its pin low");
    a_pos_after_ramp: assert property
        ($rose(o_rails.positive_rail_en) |-> $past(i_boost_ss_done, 3))
        else $error("positive rail rose before boost ramp done");
    a_pos_needs_boost: assert property (o_rails.positive_rail_en |-> o_rails.boost_rail_en)
        else $error("positive rail on without boost");
    a_neg_needs_boost: assert property (o_rails.negative_rail_en |-> o_rails.boost_rail_en)
        else $error("negative rail on without boost");
    a_neg_dis_off: assert property (o_rails.negative_rail_en |-> !o_rails.neg_discharge_en)
        else $error("negative pull-down on while rail runs");
    a_boost_pfm_gate: assert property
        (o_rails.boost_pfm_allow |-> o_rails.boost_rail_en && $past(i_boost_pfm_en))
        else $error("boost pulse mode without permit");
    a_pump_pfm_gate: assert property
        (o_rails.pump_pfm_allow |-> o_rails.negative_rail_en && $past(i_pump_pfm_en))
        else $error("pump pulse mode without permit");
endmodule

bind drs_sequencer drs_seq_props u_props (.i_ref_clk, .i_resetn, .i_neg_rail_enable_pin,
    .i_input_uvlo, .i_boost_ss_done, .i_boost_pfm_en, .i_pump_pfm_en, .o_rails);

// File: dv/drs_boost_model.sv
// stand-in for the analog boost: reports ramp done after a fixed count
// assumes boost enable comes from the sequencer on the same clock
`timescale 1ns/100ps

module drs_boost_model
#(
    parameter int P_RAMP = 5
)
(
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    input  wire logic i_boost_on,
    input  wire logic i_slow,
    output logic      o_ss_done = 1'b0
);
    int cnt;
    // fixed slope, so slow mode stands for a higher target voltage
    always @(posedge i_ref_clk or negedge i_resetn)
        if (!i_resetn)
        begin
            cnt <= 0;
            o_ss_done <= 1'b0;
        end
        else
        begin
            cnt <= i_boost_on ? cnt + 1 : 0;
            o_ss_done <= i_boost_on && cnt >= (i_slow ? 2 * P_RAMP : P_RAMP);
        end
endmodule

// File: dv/tb_top.sv
// self-checking bench for the rail sequencer with a boost ramp stand-in
// assumes shortened interval parameters and one 100 MHz clock
`timescale 1ns/100ps

module tb_top;
    import drs_pkg::*;
    localparam int SEQ = 20;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       pin_p = 1'b0;
    logic       pin_n = 1'b0;
    logic       uv = 1'b0;
    logic       slow = 1'b0;
    logic [1:0] pfm = 2'h0;
    logic       we = 1'b0;
    logic       stop = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [7:0] seen;
    logic [7:0] aux;
    logic       bss;
    drs_rails_s rails;
    drs_ss_s    ss;
    int         err_total = 0;
    int         checked = 0;
    int         n;
    logic [7:0] exp_q[$];
    string      name_q[$];
    event       look;

    always #5 clk = ~clk;

    drs_sequencer #(.P_SEQ_DLY_CYC(SEQ), .P_POS_SS_CYC(12), .P_NEG_SS_CYC(18),
        .P_FAST_SS_CYC(7), .P_BOOST_SS_CYC(5)) DUT (.i_ref_clk(clk), .i_resetn(rstn),
        .i_pos_rail_enable_pin(pin_p), .i_neg_rail_enable_pin(pin_n), .i_input_uvlo(uv),
        .i_boost_ss_done(bss), .i_boost_pfm_en(pfm[1]), .i_pump_pfm_en(pfm[0]),
        .i_reg_wr(we), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_xfer_stop(stop),
        .o_reg_rdata(rdata), .o_rails(rails), .o_ss_cycles(ss));

    drs_boost_model #(.P_RAMP(5)) u_boost (.i_ref_clk(clk), .i_resetn(rstn),
        .i_boost_on(rails.boost_rail_en), .i_slow(slow), .o_ss_done(bss));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [7:0] s, logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // #2 keeps two notes from landing while the watcher is still busy
    task automatic note(string nm, logic [7:0] e);
        name_q.push_back(nm);
        exp_q.push_back(e);
        -> look;
        #2;
    endtask

    task automatic edge1(int k = 1);
        repeat (k) @(posedge clk);
        pfm <= 2'($urandom);
    endtask

    task automatic settle(int k);
        edge1(k);
        #1;
    endtask

    task automatic reg_wr(logic [7:0] a, logic [7:0] d, bit with_stop);
        edge1();
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        edge1();
        we <= 1'b0;
        stop <= with_stop;
        edge1();
        stop <= 1'b0;
    endtask

    task automatic reg_rd(logic [7:0] a, logic [7:0] e);
        edge1();
        addr <= a;
        settle(2);
        note("rdata", e);
    endtask

    task automatic wait_rail(int b, logic v);
        for (n = 0; n < 300 && rails[b] !== v; n++)
            @(posedge clk) #1;
    endtask

    task automatic pins(logic p, logic q);
        edge1();
        pin_p <= p;
        pin_n <= q;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(look)
    begin
        #1;
        case (name_q[0])
            "rdata":  seen = rdata;
            "rails":  seen = {5'h00, rails[6:4]};
            "dis":    seen = {6'h00, rails[3:2]};
            "pos_ss": seen = ss.pos_ss[7:0];
            "neg_ss": seen = ss.neg_ss[7:0];
            "boost_ss": seen = ss.boost_ss[7:0];
            default:  seen = aux;
        endcase
        check(name_q.pop_front(), seen, exp_q.pop_front());
    end

    initial
    begin
        #200_000;
        err_total++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(31));
        edge1(2);
        rstn <= 1'b1;
        reg_rd(8'h05, 8'h27);
        reg_rd(8'h04, 8'h00);
        reg_rd(8'h07, 8'h00);
        note("dis", 8'h03);
        note("pos_ss", 8'h0C);
        note("neg_ss", 8'h12);
        note("boost_ss", 8'h05);
        reg_wr(8'h05, 8'hCF, 1'b1);
        reg_rd(8'h05, 8'hC7);
        note("dis", 8'h00);
        note("pos_ss", 8'h07);
        note("neg_ss", 8'h07);
        reg_wr(8'h05, 8'h27, 1'b1);
        reg_wr(8'h05, 8'h00, 1'b0);
        reg_rd(8'h05, 8'h27);
        // sequenced start, both pins together
        pins(1'b1, 1'b1);
        settle(3);
        note("rails", 8'h04);
        wait_rail(5, 1'b1);
        note("rails", 8'h06);
        wait_rail(4, 1'b1);
        aux = {7'h00, n >= SEQ - 3 && n <= SEQ + 4};
        note("seq_gap", 8'h01);
        // positive pin falls first: delayed off, negative keeps running
        pins(1'b0, 1'b1);
        settle(4);
        note("rails", 8'h07);
        wait_rail(5, 1'b0);
        aux = {7'h00, n >= SEQ - 8 && n <= SEQ + 4};
        note("off_gap", 8'h01);
        note("rails", 8'h05);
        pins(1'b0, 1'b0);
        settle(3);
        note("rails", 8'h00);
        note("dis", 8'h03);
        // negative pin falls alone: positive pull-down pulse
        pins(1'b1, 1'b1);
        wait_rail(4, 1'b1);
        pins(1'b1, 1'b0);
        settle(3);
        note("rails", 8'h06);
        note("dis", 8'h03);
        wait_rail(3, 1'b0);
        aux = {7'h00, n >= SEQ - 6 && n <= SEQ + 4};
        note("dis_gap", 8'h01);
        // immediate off
        reg_wr(8'h05, 8'h37, 1'b1);
        pins(1'b0, 1'b0);
        settle(3);
        note("rails", 8'h00);
        // both rails together, slow boost ramp
        slow <= 1'b1;
        reg_wr(8'h04, 8'h10, 1'b1);
        pins(1'b1, 1'b1);
        wait_rail(5, 1'b1);
        note("rails", 8'h07);
        // enable bits gate each rail
        reg_wr(8'h05, 8'h33, 1'b1);
        settle(2);
        note("rails", 8'h05);
        reg_wr(8'h05, 8'h35, 1'b1);
        settle(2);
        note("rails", 8'h06);
        reg_wr(8'h05, 8'h34, 1'b1);
        settle(2);
        note("rails", 8'h00);
        reg_wr(8'h05, 8'h37, 1'b1);
        wait_rail(4, 1'b1);
        edge1();
        uv <= 1'b1;
        settle(3);
        note("rails", 8'h00);
        edge1();
        uv <= 1'b0;
        rstn <= 1'b0;
        edge1(2);
        rstn <= 1'b1;
        reg_rd(8'h05, 8'h27);
        give_verdict();
    end
endmodule
